// >>> hdl/ksrd_defs.svh
// offsets, field positions, reset values and timing counts of the row driver
`ifndef KSRD_DEFS_SVH
`define KSRD_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define KSRD_OFS_CTRL      12'h004
`define KSRD_OFS_EXT       12'h014
`define KSRD_OFS_STAT      12'h018
`define KSRD_OFS_ROWS      12'h01c

// ----------------------------------------------------------------------
// control, ext and status register fields and reset values
// ----------------------------------------------------------------------
`define KSRD_BIT_POL       7
`define KSRD_BIT_DIS       6
`define KSRD_BIT_ALL       5
`define KSRD_IDX_MSB       4
`define KSRD_IDX_LSB       0
`define KSRD_CTRL_RST      8'h40
`define KSRD_BIT_PREDRIVE  0
`define KSRD_EXT_RST       1'b0
`define KSRD_BIT_LOWPWR    0
`define KSRD_BIT_BUSY      1

// ----------------------------------------------------------------------
// row count and timing
// ----------------------------------------------------------------------
`define KSRD_NUM_ROWS      18
`define KSRD_CLK_NS        25
`define KSRD_PREDRIVE_NS   100
`define KSRD_PREDRIVE_CYC  ((`KSRD_PREDRIVE_NS + `KSRD_CLK_NS - 1) / `KSRD_CLK_NS)

`endif

// >>> hdl/ksrd_pkg.sv
// types shared by the row driver modules
package ksrd_pkg;

  // ----------------------------------------------------------------------
  // bus words
  // ----------------------------------------------------------------------
  typedef logic [11:0] ksrd_addr_t;
  typedef logic [31:0] ksrd_word_t;
  typedef logic [3:0]  ksrd_strb_t;

  // ----------------------------------------------------------------------
  // control register image, msb first
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       polarity;
    logic       disable_scan;
    logic       select_all;
    logic [4:0] index;
  } ksrd_ctrl_t;

endpackage

// >>> hdl/ksrd_row_if.sv
// row request and pin state between the register block and the pin stage
`timescale 1ns/10ps
interface ksrd_row_if #(
  parameter int unsigned N = 18
);
  logic [N-1:0] level;
  logic         enable;
  logic         predrive_en;
  logic [N-1:0] row_level;
  logic [N-1:0] row_oe;
  logic         predrive_busy;

  // register block drives the request, pin stage answers
  modport src  (output level, enable, predrive_en,
                input  row_level, row_oe, predrive_busy);
  modport pins (input  level, enable, predrive_en,
                output row_level, row_oe, predrive_busy);
endinterface

// >>> hdl/ksrd_row_pins.sv
// registered row pin stage with optional high predrive pulse
`timescale 1ns/10ps
`include "ksrd_defs.svh"
module ksrd_row_pins #(
  parameter int unsigned NUM_ROWS     = `KSRD_NUM_ROWS,
  parameter int unsigned PREDRIVE_CYC = `KSRD_PREDRIVE_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // row request in, pin state out
  ksrd_row_if.pins rows
);
  import ksrd_pkg::*;

  localparam int unsigned CW = $clog2(PREDRIVE_CYC + 1);

  // ----------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------
  if (PREDRIVE_CYC < 1) begin : g_bad_cyc
    $error("predrive count must be at least one cycle");
  end

  // ----------------------------------------------------------------------
  // enable history, used to predrive rows when scanning restarts
  // ----------------------------------------------------------------------
  logic                en_r;
  logic                en_nxt;
  logic [NUM_ROWS-1:0] busy_v;

  always_comb begin
    en_nxt = rows.enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end

  assign rows.predrive_busy = |busy_v;

  // ----------------------------------------------------------------------
  // one pin stage per row
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NUM_ROWS; i++) begin : g_row
    logic          lvl_r;
    logic          lvl_nxt;
    logic          oe_r;
    logic          oe_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          start;

    // a row rising to high under predrive is pushed high, then released
    always_comb begin
      start   = rows.enable & rows.predrive_en & rows.level[i] & (~lvl_r | ~en_r);
      cnt_nxt = cnt_r;
      if (!rows.enable || !rows.predrive_en) begin
        cnt_nxt = '0;
      end else if (start) begin
        cnt_nxt = CW'(PREDRIVE_CYC);
      end else if (cnt_r != '0) begin
        cnt_nxt = cnt_r - 1'b1;
      end
      lvl_nxt = rows.level[i];
      // disabled scan turns every buffer off whatever the fields hold
      oe_nxt  = rows.enable &
                (~rows.predrive_en | ~rows.level[i] | start | (cnt_r > CW'(1)));
    end

    // pins change on the edge after the request changes
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lvl_r <= 1'b1;
        oe_r  <= 1'b0;
        cnt_r <= '0;
      end else begin
        lvl_r <= lvl_nxt;
        oe_r  <= oe_nxt;
        cnt_r <= cnt_nxt;
      end
    end

    assign rows.row_level[i] = lvl_r;
    assign rows.row_oe[i]    = oe_r;
    assign busy_v[i]         = (cnt_r != '0);
  end

endmodule

// >>> hdl/ksrd_scan_rows.sv
// keyboard scan row driver: apb registers, row decode and pin stage
`timescale 1ns/10ps
`include "ksrd_defs.svh"
module ksrd_scan_rows #(
  parameter int unsigned NUM_ROWS     = `KSRD_NUM_ROWS,
  parameter int unsigned PREDRIVE_CYC = `KSRD_PREDRIVE_CYC
) (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire ksrd_pkg::ksrd_addr_t paddr,
  input  wire ksrd_pkg::ksrd_word_t pwdata,
  input  wire ksrd_pkg::ksrd_strb_t pstrb,
  output wire ksrd_pkg::ksrd_word_t prdata,
  output wire logic               pready,
  output wire logic               pslverr,
  // row pins, open drain style: level plus buffer enable
  output wire logic [NUM_ROWS-1:0] scan_row_out,
  output wire logic [NUM_ROWS-1:0] scan_row_oe,
  // power management
  output wire logic               scan_low_power
);
  import ksrd_pkg::*;

  // ----------------------------------------------------------------------
  // parameter check: the index field reaches 32 rows at most
  // ----------------------------------------------------------------------
  if (NUM_ROWS < 1 || NUM_ROWS > 32) begin : g_bad_rows
    $error("row count must lie between 1 and 32");
  end

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  ksrd_ctrl_t          ctrl_r;
  ksrd_ctrl_t          ctrl_nxt;
  logic                pre_r;
  logic                pre_nxt;
  ksrd_word_t          rdata_r;
  ksrd_word_t          rdata_nxt;
  ksrd_word_t          rd_word;
  logic                hit;
  logic                wr_acc;
  logic                rd_setup;
  logic                idx_in_range;
  logic [NUM_ROWS-1:0] level_v;

  ksrd_row_if #(.N(NUM_ROWS)) row_bus ();

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  // zero wait states: every access ends in its first access cycle
  always_comb begin
    hit = (paddr == `KSRD_OFS_CTRL) || (paddr == `KSRD_OFS_EXT) ||
          (paddr == `KSRD_OFS_STAT) || (paddr == `KSRD_OFS_ROWS);
  end

  assign wr_acc   = psel & penable & pwrite & hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit; // unmapped: error, no effect

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // only byte lane 0 carries fields, so a write without it changes nothing
  always_comb begin
    ctrl_nxt = ctrl_r;
    pre_nxt  = pre_r;
    if (wr_acc && pstrb[0]) begin
      if (paddr == `KSRD_OFS_CTRL) begin
        ctrl_nxt.polarity     = pwdata[`KSRD_BIT_POL];
        ctrl_nxt.disable_scan = pwdata[`KSRD_BIT_DIS];
        ctrl_nxt.select_all   = pwdata[`KSRD_BIT_ALL];
        ctrl_nxt.index        = pwdata[`KSRD_IDX_MSB:`KSRD_IDX_LSB];
      end
      if (paddr == `KSRD_OFS_EXT) begin
        pre_nxt = pwdata[`KSRD_BIT_PREDRIVE];
      end
    end
  end

  // scan starts disabled after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= ksrd_ctrl_t'(`KSRD_CTRL_RST);
      pre_r  <= `KSRD_EXT_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      pre_r  <= pre_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    unique case (paddr)
      `KSRD_OFS_CTRL: rd_word = ksrd_word_t'(ctrl_r);
      `KSRD_OFS_EXT:  rd_word = ksrd_word_t'(pre_r);
      `KSRD_OFS_STAT: begin
        rd_word[`KSRD_BIT_LOWPWR] = ctrl_r.disable_scan;
        rd_word[`KSRD_BIT_BUSY]   = row_bus.predrive_busy;
      end
      `KSRD_OFS_ROWS: rd_word = ksrd_word_t'(row_bus.row_level);
      default:        rd_word = '0;
    endcase
  end

  // read data caught in the setup cycle so prdata comes from a flop;
  // pin state read this way is one cycle older than the access edge
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_setup) begin
      rdata_nxt = rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata = rdata_r;

  // ----------------------------------------------------------------------
  // row level decode
  // ----------------------------------------------------------------------
  assign idx_in_range = (32'(ctrl_r.index) < NUM_ROWS);

  for (genvar i = 0; i < NUM_ROWS; i++) begin : g_dec
    // polarity is the selected level; unselected rows take the other one
    always_comb begin
      if (ctrl_r.select_all) begin
        level_v[i] = ctrl_r.polarity;
      end else if (!idx_in_range) begin
        level_v[i] = ~ctrl_r.polarity;
      end else if (ctrl_r.index == 5'(i)) begin
        level_v[i] = ctrl_r.polarity;
      end else begin
        level_v[i] = ~ctrl_r.polarity;
      end
    end
  end

  assign row_bus.level       = level_v;
  assign row_bus.enable      = ~ctrl_r.disable_scan;
  assign row_bus.predrive_en = pre_r;

  // ----------------------------------------------------------------------
  // pin stage
  // ----------------------------------------------------------------------
  ksrd_row_pins #(
    .NUM_ROWS     (NUM_ROWS),
    .PREDRIVE_CYC (PREDRIVE_CYC)
  ) u_pins (
    .pclk    (pclk),
    .presetn (presetn),
    .rows    (row_bus.pins)
  );

  assign scan_row_out = row_bus.row_level;
  assign scan_row_oe  = row_bus.row_oe;

  // disabled block holds no sleep inhibit; the flag comes from a flop
  assign scan_low_power = ctrl_r.disable_scan;

endmodule

// >>> sim/ksrd_scan_rows_props.sv
// port checker for the scan row driver, bound to its top
`timescale 1ns/10ps
module ksrd_scan_rows_props #(
  parameter int unsigned NUM_ROWS = 18
) (
  // clock and reset
  input logic                 pclk,
  input logic                 presetn,
  // apb slave side
  input logic                 psel,
  input logic                 penable,
  input logic                 pwrite,
  input ksrd_pkg::ksrd_addr_t paddr,
  input ksrd_pkg::ksrd_word_t pwdata,
  input ksrd_pkg::ksrd_strb_t pstrb,
  input ksrd_pkg::ksrd_word_t prdata,
  input logic                 pready,
  input logic                 pslverr,
  // row pins and power
  input logic [NUM_ROWS-1:0]  scan_row_out,
  input logic [NUM_ROWS-1:0]  scan_row_oe,
  input logic                 scan_low_power
);
  import ksrd_pkg::*;
  logic [7:0]          ctl_r, ctl_nxt;
  logic                pd_r, pd_nxt, wr_go;
  logic [NUM_ROWS-1:0] lvl;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow of control and predrive, taken at the same edge as the design
  assign wr_go = psel && penable && pwrite && pstrb[0];
  always_comb begin
    ctl_nxt = ctl_r;
    pd_nxt  = pd_r;
    if (wr_go && paddr == 12'h004) ctl_nxt = pwdata[7:0];
    if (wr_go && paddr == 12'h014) pd_nxt = pwdata[0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 8'h40;
      pd_r  <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      pd_r  <= pd_nxt;
    end
  end
  // expected levels; out-of-range index leaves every row inactive
  always_comb begin
    lvl = {NUM_ROWS{~ctl_r[7]}};
    if (ctl_r[5]) lvl = {NUM_ROWS{ctl_r[7]}};
    else if (ctl_r[4:0] < NUM_ROWS) lvl[ctl_r[4:0]] = ctl_r[7];
  end

  a_disabled_oe_off: assert property (ctl_r[6] |=> scan_row_oe == '0)
    else $error("row buffers on while disabled");
  a_reset_disabled: assert property ($rose(presetn) |-> scan_low_power && !(|scan_row_oe))
    else $error("not disabled after reset");
  a_single_level: assert property (!ctl_r[6] && !ctl_r[5] && ctl_r[4:0] < 5'h12
    |=> scan_row_out == $past(lvl)) else $error("single row level wrong");
  a_over_level: assert property (!ctl_r[6] && !ctl_r[5] && ctl_r[4:0] > 5'h11
    |=> scan_row_out == {NUM_ROWS{~$past(ctl_r[7])}}) else $error("over range level wrong");
  a_all_level: assert property (!ctl_r[6] && ctl_r[5]
    |=> scan_row_out == {NUM_ROWS{$past(ctl_r[7])}}) else $error("select all level wrong");
  a_write_to_pins: assert property (wr_go && paddr == 12'h004 && pwdata[5] && !pwdata[6]
    |-> ##2 scan_row_out == {NUM_ROWS{$past(pwdata[7], 2)}}) else $error("write latency wrong");
  a_enabled_oe_on: assert property (!ctl_r[6] && !pd_r |=> &scan_row_oe)
    else $error("row buffer off while scanning");
  a_low_power_mode: assert property (ctl_r[6] == $past(ctl_r[6])
    |-> scan_low_power == ctl_r[6]) else $error("low power flag wrong");
  a_predrive_pulse: assert property (pd_r && !ctl_r[6] && $rose(scan_row_out[0])
    |-> scan_row_oe[0] [*4] ##1 !(scan_row_oe[0] && scan_row_out[0]))
    else $error("predrive pulse wrong");

  c_select_all: cover property (wr_go && paddr == 12'h004 && pwdata[5] && !pwdata[6]);
  c_predrive:   cover property (pd_r && $rose(scan_row_out[0]));
  c_unmapped:   cover property (psel && penable && pslverr);
endmodule

bind ksrd_scan_rows ksrd_scan_rows_props #(.NUM_ROWS(NUM_ROWS)) u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .scan_row_out, .scan_row_oe, .scan_low_power);

// >>> sim/ksrd_matrix_model.sv
// switch matrix rows with pull-ups, as the keys see them
`timescale 1ns/10ps
module ksrd_matrix_model #(
  parameter int unsigned NUM_ROWS = 18
) (
  // row pins from the driver
  input  logic [NUM_ROWS-1:0] row_out,
  input  logic [NUM_ROWS-1:0] row_oe,
  // resolved wire level
  output logic [NUM_ROWS-1:0] row_wire
);
  // a released row floats up through its pull-up, never holds the old level
  always_comb begin
    for (int i = 0; i < NUM_ROWS; i++) begin
      row_wire[i] = row_oe[i] ? row_out[i] : 1'b1;
    end
  end
endmodule

// >>> sim/ksrd_scan_rows_test.sv
// self-checking bench for the scan row driver
`timescale 1ns/10ps
module ksrd_scan_rows_test;
  import ksrd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, scan_low_power, err;
  ksrd_addr_t  paddr;
  ksrd_word_t  pwdata, prdata, rd;
  ksrd_strb_t  pstrb;
  logic [17:0] row_out, row_oe, row_wire;
  int          error_cnt, checked;

  ksrd_scan_rows dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .scan_row_out(row_out), .scan_row_oe(row_oe), .scan_low_power);
  ksrd_matrix_model mdl (.row_out, .row_oe, .row_wire);

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  task automatic end_of_test();
    $display("errors %0d of %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic w, input ksrd_addr_t a, input ksrd_word_t d,
                     input ksrd_strb_t s);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic wr(input ksrd_addr_t a, input ksrd_word_t d);
    apb(1'b1, a, d, 4'hf);
  endtask
  // pins settle one edge after the write edge
  task automatic pins(input logic [17:0] lv, input logic [17:0] oe);
    @(posedge pclk);
    #1;
    cmp({14'h0, row_out}, {14'h0, lv});
    cmp({14'h0, row_oe}, {14'h0, oe});
  endtask

  task automatic t_reset();
    apb(1'b0, 12'h004, '0, 4'hf);
    cmp(rd, 32'h40);
    cmp({14'h0, row_wire}, 32'h3ffff);
    cmp({31'h0, scan_low_power}, 32'h1);
    apb(1'b0, 12'h018, '0, 4'hf);
    cmp(rd, 32'h1);
  endtask
  // every polarity, select-all and index combination while scanning
  task automatic t_decode();
    logic [17:0] e;
    for (int m = 0; m < 128; m++) begin
      wr(12'h004, {24'h0, m[6], 1'b0, m[5:0]});
      e = m[5] ? {18{m[6]}} : {18{~m[6]}};
      if (!m[5] && m[4:0] < 18) e[m[4:0]] = m[6];
      pins(e, 18'h3ffff);
    end
  endtask
  task automatic t_disable();
    logic [17:0] e;
    for (int k = 0; k < 4; k++) begin
      wr(12'h004, {24'h0, k[1], 1'b1, k[0], 5'h11});
      // levels keep following the decode while the buffers are off
      e = k[0] ? {18{k[1]}} : {k[1], {17{~k[1]}}};
      pins(e, 18'h0);
      cmp({14'h0, row_wire}, 32'h3ffff);
      cmp({31'h0, scan_low_power}, 32'h1);
    end
    wr(12'h004, 32'h05);
    pins(18'h3ffdf, 18'h3ffff);
    cmp({31'h0, scan_low_power}, 32'h0);
  endtask
  task automatic t_regs();
    apb(1'b1, 12'h004, 32'h40, 4'h0);
    apb(1'b0, 12'h004, '0, 4'hf);
    cmp({err, rd[30:0]}, 32'h05);
    apb(1'b0, 12'h018, '0, 4'hf);
    cmp(rd, 32'h0);
    apb(1'b0, 12'h01c, '0, 4'hf);
    cmp(rd, 32'h3ffdf);
    apb(1'b0, 12'h000, '0, 4'hf);
    cmp({err, rd[30:0]}, 32'h80000000);
  endtask
  // row 0 rises under predrive: pushed four cycles, then left to the pull-up
  task automatic t_predrive();
    wr(12'h004, 32'hc1);
    wr(12'h014, 32'h1);
    apb(1'b0, 12'h014, '0, 4'hf);
    cmp(rd, 32'h1);
    wr(12'h004, 32'h81);
    // status caught in the setup cycle, while the pulse on row 1 still runs
    apb(1'b0, 12'h018, '0, 4'hf);
    cmp(rd, 32'h2);
    repeat (8) @(posedge pclk);
    cmp({14'h0, row_oe}, 32'h3fffd);
    wr(12'h004, 32'h80);
    pins(18'h1, 18'h3ffff);
    repeat (3) @(posedge pclk);
    #1;
    cmp({14'h0, row_oe}, 32'h3ffff);
    pins(18'h1, 18'h3fffe);
    cmp({14'h0, row_wire}, 32'h1);
    wr(12'h004, 32'h40);
    wr(12'h014, 32'h0);
  endtask

  initial begin
    pclk      = 1'b0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = '0;
    pstrb     = '0;
    error_cnt = 0;
    checked   = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_decode();
    t_disable();
    t_regs();
    t_predrive();
    end_of_test();
  end
endmodule
